// ==== hdl/cif_busoff_counter.sv ====
// Bus-off recovery counter: counts runs of consecutive recessive bits
module cif_busoff_counter import cif_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic run,
    input wire logic bit_tick,
    input wire logic rx_recessive,
    output logic seq_done
);
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BIT_CNT_W-1:0] next_bit_cnt;
    logic [SEQ_CNT_W-1:0] seq_cnt;
    logic [SEQ_CNT_W-1:0] next_seq_cnt;

    assign seq_done = (seq_cnt == SEQ_COUNT);

    always_comb begin
        next_bit_cnt = bit_cnt;
        next_seq_cnt = seq_cnt;
        if (clear) begin
            next_bit_cnt = '0;
            next_seq_cnt = '0;
        end else if (run && bit_tick && !seq_done) begin
            // A dominant bit restarts the current run only, finished runs stay counted
            if (!rx_recessive) begin
                next_bit_cnt = '0;
            end else if (bit_cnt == RECESSIVE_RUN - 4'h1) begin
                next_bit_cnt = '0;
                next_seq_cnt = seq_cnt + 8'h01;
            end else begin
                next_bit_cnt = bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt <= '0;
            seq_cnt <= '0;
        end else begin
            bit_cnt <= next_bit_cnt;
            seq_cnt <= next_seq_cnt;
        end
    end

endmodule : cif_busoff_counter

// ==== hdl/cif_flag_ctrl.sv ====
// CAN interrupt flags, acknowledge, mode handshakes and bus-off recovery, AXI4-Lite slave
// Notes on behaviour
// [RQ1] Empty transmit buffer sets its empty flag
// [RQ2] Received frame in foreground sets receive-full flag
// [RQ3] Next queued frame moved in sets it again
// [RQ4] Bus activity in sleep or power-down wakes
// [RQ5] Wake only after sleep, wake-up enabled, enabled
// [RQ6] Frame lost to full FIFO sets overrun
// [RQ7] Bus state change sets flag, reports states
// [RQ8] Interrupt stays high while its flags set
// [RQ9] Write one clears a flag, zero keeps
// [RQ10] Clear ignored while setting condition persists
// [RQ11] Handler clears only its own flag bits
// [RQ12] Start: enable, configure in init, leave init
// [RQ13] Reconfigure via sleep, then init handshake
// [RQ14] Default: leave bus-off after 128 recessive runs
// [RQ15] User mode also waits for hold clear
// [RQ16] Four maskable requests: wake, error, rx, tx
// [RQ17] Recessive run counting pauses during sleep
// [RQ18] Requests are registered OR of enabled flags
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module cif_flag_ctrl import cif_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic can_rx_pin,
    input wire logic bit_tick,
    input wire logic [NUM_TXBUF-1:0] tx_done,
    input wire logic rx_frame_stored,
    input wire logic bus_idle,
    input wire logic power_down,
    input wire logic busoff,
    input wire logic [8:0] tx_err_cnt,
    input wire logic [8:0] rx_err_cnt,
    output logic [NUM_TXBUF-1:0] tx_scheduled,
    output logic rx_fg_load,
    output logic busoff_recover,
    output logic init_acknowledge,
    output logic sleep_acknowledge,
    output logic irq_wakeup,
    output logic irq_error,
    output logic irq_rx,
    output logic irq_tx
);
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return a == OFS_CTRL || a == OFS_RFLAG || a == OFS_TFLAG || a == OFS_IEN
            || a == OFS_MISC || a == OFS_STATUS;
    endfunction : addr_known

    function automatic logic [1:0] bus_state(input logic [8:0] cnt);
        if (cnt >= PASSIVE_LIMIT) begin
            return BS_ERR;
        end else if (cnt >= WARN_LIMIT) begin
            return BS_WARN;
        end
        return BS_OK;
    endfunction : bus_state

    function automatic logic is_dormant(input cif_mode_t m);
        return m == M_SLEEP || m == M_POWERDOWN;
    endfunction : is_dormant

    // Bus slave state
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic aw_held, next_aw_held;
    logic [31:0] w_data, next_w_data;
    logic w_lane0, next_w_lane0;
    logic w_held, next_w_held;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
    logic [31:0] next_rdata;

    // Core state
    cif_ctrl_t ctrl, next_ctrl;
    cif_ien_t ien, next_ien;
    cif_rflag_t rflag, next_rflag;
    cif_mode_t mode, next_mode;
    logic [NUM_TXBUF-1:0] txe, next_txe;
    logic [2:0] q_cnt, next_q_cnt;
    logic hold, next_hold, busoff_prev, slept_pd, next_slept_pd;
    logic rx_s1, rx_s2, rx_s3, rx_level, next_rx_level;
    logic next_fg_load, next_recover;
    logic next_irq_wakeup, next_irq_error, next_irq_rx, next_irq_tx;
    logic seq_done, cnt_run, cnt_clear;

    logic wr_fire, wr_ctrl, wr_rflag, wr_tflag, wr_misc;
    logic [1:0] tx_bus_state_field_new, rx_bus_state_field_new;
    logic rxf_set, ovr_set, csc_set, wake_set, activity, fg_move, sleep_ok;
    logic [7:0] clr;

    cif_busoff_counter cif_busoff_counter_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(cnt_clear),
        .run(cnt_run),
        .bit_tick(bit_tick),
        .rx_recessive(rx_level),
        .seq_done(seq_done)
    );

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && w_lane0 && aw_addr == OFS_CTRL;
    assign wr_rflag = wr_fire && w_lane0 && aw_addr == OFS_RFLAG;
    assign wr_tflag = wr_fire && w_lane0 && aw_addr == OFS_TFLAG;
    assign wr_misc = wr_fire && w_lane0 && aw_addr == OFS_MISC;
    assign clr = w_data[7:0];

    // Pin level changes only once the second and third stages agree
    assign next_rx_level = (rx_s2 == rx_s3) ? rx_s3 : rx_level;
    assign activity = ctrl.wakeup_enable && !rx_level;

    assign cnt_run = busoff && !is_dormant(mode); // RQ17
    assign cnt_clear = !busoff || busoff_recover;

    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_held = aw_held;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_w_held = w_held;
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_addr = s_axi_awaddr;
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_data = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
            next_w_held = 1'b1;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_CTRL: next_rdata = {27'h0, ctrl};
                OFS_RFLAG: next_rdata = {24'h0, rflag};
                OFS_TFLAG: next_rdata = {29'h0, txe};
                OFS_IEN: next_rdata = {25'h0, ien};
                OFS_MISC: next_rdata = {31'h0, hold};
                OFS_STATUS: next_rdata = {29'h0, busoff, sleep_acknowledge, init_acknowledge};
                default: next_rdata = 32'h0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= '0;
            aw_held <= 1'b0;
            w_data <= 32'h0;
            w_lane0 <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            aw_addr <= next_aw_addr;
            aw_held <= next_aw_held;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            w_held <= next_w_held;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    always_comb begin
        tx_bus_state_field_new = busoff ? BS_OFF : bus_state(tx_err_cnt); // RQ7
        rx_bus_state_field_new = bus_state(rx_err_cnt); // RQ7
        csc_set = tx_bus_state_field_new != rflag.tx_bus_state_field || rx_bus_state_field_new != rflag.rx_bus_state_field;
        ovr_set = rx_frame_stored && q_cnt == RX_FIFO_DEPTH; // RQ6
        // No new frame enters the foreground while asleep
        fg_move = !is_dormant(mode) && !rflag.rx_full_flag
            && (q_cnt != 3'h0 || rx_frame_stored); // RQ2 RQ3
        rxf_set = fg_move;
        sleep_ok = &txe && bus_idle;
        wake_set = 1'b0;
        next_ctrl = ctrl;
        next_ien = ien;
        next_mode = mode;
        next_slept_pd = slept_pd;
        next_q_cnt = q_cnt;
        if (wr_ctrl) begin
            next_ctrl = cif_ctrl_t'(w_data[4:0]);
            // Sleep request cannot be withdrawn before sleep has been reached
            if (ctrl.sleep_request && mode != M_SLEEP) begin
                next_ctrl.sleep_request = 1'b1;
            end
        end
        if (wr_fire && w_lane0 && aw_addr == OFS_IEN) begin
            next_ien = cif_ien_t'(w_data[6:0]); // RQ16
        end
        case (mode)
            M_DISABLED: begin
                if (ctrl.module_enable_bit) begin
                    next_mode = ctrl.init_request ? M_INIT : M_RUN; // RQ12
                end
            end
            M_INIT: begin
                if (!ctrl.init_request) begin
                    next_mode = M_RUN; // RQ12
                end
            end
            M_RUN: begin
                if (power_down) begin
                    next_mode = M_POWERDOWN;
                    next_slept_pd = 1'b0;
                end else if (ctrl.init_request) begin
                    next_mode = M_INIT;
                end else if (ctrl.sleep_request && sleep_ok) begin
                    next_mode = M_SLEEP; // RQ13
                end
            end
            M_SLEEP: begin
                if (power_down) begin
                    next_mode = M_POWERDOWN;
                    next_slept_pd = 1'b1; // RQ5
                end else if (ctrl.init_request) begin
                    next_mode = M_INIT; // RQ13
                end else if (activity) begin
                    wake_set = 1'b1; // RQ4
                    next_mode = M_RUN;
                    next_ctrl.sleep_request = 1'b0;
                end else if (!ctrl.sleep_request) begin
                    next_mode = M_RUN;
                end
            end
            M_POWERDOWN: begin
                if (slept_pd && activity) begin
                    wake_set = 1'b1; // RQ4 RQ5
                    next_mode = M_RUN;
                    next_ctrl.sleep_request = 1'b0;
                end else if (!power_down) begin
                    next_mode = slept_pd ? M_SLEEP : M_RUN;
                end
            end
            default: next_mode = M_DISABLED;
        endcase
        if (!ctrl.module_enable_bit) begin
            next_mode = M_DISABLED;
        end
        next_q_cnt = q_cnt + ((rx_frame_stored && !ovr_set) ? 3'h1 : 3'h0)
            - (fg_move ? 3'h1 : 3'h0);
        // Set wins over a simultaneous write-one clear
        next_rflag = rflag;
        next_rflag.tx_bus_state_field = tx_bus_state_field_new;
        next_rflag.rx_bus_state_field = rx_bus_state_field_new;
        next_rflag.rx_full_flag = rxf_set
            || (rflag.rx_full_flag && !(wr_rflag && clr[0])); // RQ9 RQ10
        next_rflag.overrun_flag = ovr_set
            || (rflag.overrun_flag && !(wr_rflag && clr[1])); // RQ6 RQ9 RQ10
        next_rflag.status_change_flag = csc_set
            || (rflag.status_change_flag && !(wr_rflag && clr[6])); // RQ7 RQ10
        next_rflag.wakeup_flag = wake_set
            || (rflag.wakeup_flag && !(wr_rflag && clr[7] && !activity)); // RQ10
        next_txe = tx_done | (txe & ~({NUM_TXBUF{wr_tflag}} & clr[2:0])); // RQ1 RQ9 RQ10
        next_hold = (busoff && !busoff_prev && ctrl.busoff_recovery_mode)
            || (hold && !(wr_misc && clr[0])); // RQ15
        next_recover = busoff && seq_done && !busoff_recover
            && (!ctrl.busoff_recovery_mode || !hold); // RQ14 RQ15
        next_fg_load = fg_move;
        next_irq_rx = next_rflag.rx_full_flag && ien.rx_full_irq_enable; // RQ8 RQ18
        next_irq_error = (next_rflag.overrun_flag && ien.overrun_irq_enable)
            || (next_rflag.status_change_flag && ien.status_change_irq_enable); // RQ8 RQ18
        next_irq_wakeup = next_rflag.wakeup_flag && ien.wakeup_irq_enable; // RQ8 RQ16
        next_irq_tx = |(next_txe & ien.tx_empty_irq_enable); // RQ8 RQ18
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            ien <= '0;
            rflag <= '0;
            mode <= M_DISABLED;
            slept_pd <= 1'b0;
            q_cnt <= 3'h0;
            txe <= {NUM_TXBUF{1'b1}};
            hold <= 1'b0;
            busoff_prev <= 1'b0;
            {rx_s1, rx_s2, rx_s3, rx_level} <= 4'hf;
            tx_scheduled <= '0;
            rx_fg_load <= 1'b0;
            busoff_recover <= 1'b0;
            init_acknowledge <= 1'b0;
            sleep_acknowledge <= 1'b0;
            {irq_wakeup, irq_error, irq_rx, irq_tx} <= 4'h0;
        end else begin
            ctrl <= next_ctrl;
            ien <= next_ien;
            rflag <= next_rflag;
            mode <= next_mode;
            slept_pd <= next_slept_pd;
            q_cnt <= next_q_cnt;
            txe <= next_txe;
            hold <= next_hold;
            busoff_prev <= busoff;
            rx_s1 <= can_rx_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            rx_level <= next_rx_level;
            tx_scheduled <= ~next_txe;
            rx_fg_load <= next_fg_load;
            busoff_recover <= next_recover;
            init_acknowledge <= next_mode == M_INIT;
            sleep_acknowledge <= next_mode == M_SLEEP;
            irq_wakeup <= next_irq_wakeup;
            irq_error <= next_irq_error;
            irq_rx <= next_irq_rx;
            irq_tx <= next_irq_tx;
        end
    end

    a_tx_empty_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
        (|tx_done) |=> ((txe & $past(tx_done)) == $past(tx_done)))
        else $error("transmit empty flag not set after buffer done");
    a_rx_full_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
        rx_frame_stored && !rflag.rx_full_flag && mode == M_RUN
        |=> rflag.rx_full_flag ##1 irq_rx || !ien.rx_full_irq_enable)
        else $error("receive full flag or request missing after frame");
    a_rx_refill: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
        !rflag.rx_full_flag && q_cnt != 3'h0 && mode == M_RUN |=> rflag.rx_full_flag
        && q_cnt == $past(q_cnt) - 3'h1
        + (($past(rx_frame_stored) && !$past(ovr_set)) ? 3'h1 : 3'h0))
        else $error("queued frame not moved into foreground");
    a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
        rx_frame_stored && q_cnt == RX_FIFO_DEPTH |=> rflag.overrun_flag && q_cnt <= RX_FIFO_DEPTH)
        else $error("overrun not flagged on full receive queue");
    a_state_change: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
        busoff && rflag.tx_bus_state_field != BS_OFF
        |=> rflag.status_change_flag && rflag.tx_bus_state_field == BS_OFF)
        else $error("bus-off entry not reported");
    a_err_request: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
        rflag.overrun_flag && ien.overrun_irq_enable && !(wr_rflag && clr[1]) |=> irq_error)
        else $error("error request dropped while flag set");
    a_clear_blocked: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
        wr_rflag && clr[1] && ovr_set |=> rflag.overrun_flag)
        else $error("overrun clear won over a new overrun");
    a_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
        wr_rflag && !clr[0] && rflag.rx_full_flag |=> rflag.rx_full_flag)
        else $error("writing zero cleared receive full flag");
    a_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
        !rflag.wakeup_flag ##1 rflag.wakeup_flag
        |-> $past(ctrl.wakeup_enable) && ($past(mode) == M_SLEEP || $past(slept_pd)))
        else $error("wake-up flagged without sleep and enable");
    a_auto_recover: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
        busoff && seq_done && !ctrl.busoff_recovery_mode && !busoff_recover
        |=> busoff_recover ##1 !busoff_recover)
        else $error("automatic bus-off recovery missing");
    a_hold_blocks: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
        $rose(busoff_recover) |-> !$past(ctrl.busoff_recovery_mode) || !$past(hold))
        else $error("recovery started while hold set");

endmodule : cif_flag_ctrl

// ==== hdl/cif_pkg.sv ====
// Package: register map, field layouts and types of the CAN flag and recovery block
package cif_pkg;

    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RFLAG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TFLAG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IEN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MISC = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int NUM_TXBUF = 3;

    // Receive FIFO depth, frames waiting behind the foreground buffer
    localparam logic [2:0] RX_FIFO_DEPTH = 3'h5;

    // Bus state field encodings and error counter limits
    localparam logic [1:0] BS_OK = 2'h0;
    localparam logic [1:0] BS_WARN = 2'h1;
    localparam logic [1:0] BS_ERR = 2'h2;
    localparam logic [1:0] BS_OFF = 2'h3;
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h080;

    // Bus-off recovery: 128 runs of 11 recessive bits
    localparam int BIT_CNT_W = 4;
    localparam int SEQ_CNT_W = 8;
    localparam logic [BIT_CNT_W-1:0] RECESSIVE_RUN = 4'hb;
    localparam logic [SEQ_CNT_W-1:0] SEQ_COUNT = 8'h80;

    typedef struct packed {
        logic busoff_recovery_mode;
        logic wakeup_enable;
        logic sleep_request;
        logic init_request;
        logic module_enable_bit;
    } cif_ctrl_t;

    localparam cif_ctrl_t CTRL_RESET = 5'h02;

    typedef struct packed {
        logic wakeup_flag;
        logic status_change_flag;
        logic [1:0] rx_bus_state_field;
        logic [1:0] tx_bus_state_field;
        logic overrun_flag;
        logic rx_full_flag;
    } cif_rflag_t;

    typedef struct packed {
        logic [NUM_TXBUF-1:0] tx_empty_irq_enable;
        logic rx_full_irq_enable;
        logic overrun_irq_enable;
        logic status_change_irq_enable;
        logic wakeup_irq_enable;
    } cif_ien_t;

    typedef enum logic [2:0] {
        M_DISABLED,
        M_INIT,
        M_RUN,
        M_SLEEP,
        M_POWERDOWN
    } cif_mode_t;

endpackage : cif_pkg

// ==== verification/cif_can_bus_model.sv ====
// CAN bus model: bit timing strobe and receive line of the far side
module cif_can_bus_model (
    input wire logic aclk,
    input wire logic dominant,
    output logic can_rx_pin,
    output logic bit_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase = 2'h0;
    // Bus idles recessive; a dominant level stands for wake-up activity
    assign can_rx_pin = ~dominant;
    // One bit time every four clocks keeps 128 runs of 11 bits short
    assign bit_tick = (phase == 2'h3);
    always @(posedge aclk) begin
        phase <= phase + 2'h1;
    end
endmodule : cif_can_bus_model

// ==== verification/test_cif_flag_ctrl.sv ====
// Self-checking bench of the CAN flag, wake-up and bus-off recovery block
module test_cif_flag_ctrl import cif_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rd_resp, wr_resp;
    logic [31:0] rdata, rd_val;
    logic [2:0] tx_done = 3'h0;
    logic [2:0] tx_sched;
    logic rx_stored = 1'b0, busoff = 1'b0, dominant = 1'b0, pdown = 1'b0;
    logic [8:0] tx_err = 9'h0;
    logic [8:0] rx_err = 9'h0;
    logic can_rx, tick, recover, fg_ld, init_ack, sleep_ack, irq_w, irq_e, irq_r, irq_t;
    int err_count = 0, checks_done = 0, cyc = 0, rec_count = 0, fg_count = 0;

    initial begin
        forever #20 aclk = ~aclk;
    end

    cif_can_bus_model cif_can_bus_model_i (.aclk(aclk), .dominant(dominant),
        .can_rx_pin(can_rx), .bit_tick(tick));

    cif_flag_ctrl cif_flag_ctrl_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .can_rx_pin(can_rx),
        .bit_tick(tick), .tx_done(tx_done), .rx_frame_stored(rx_stored),
        .bus_idle(1'b1), .power_down(pdown), .busoff(busoff), .tx_err_cnt(tx_err),
        .rx_err_cnt(rx_err), .tx_scheduled(tx_sched), .rx_fg_load(fg_ld),
        .busoff_recover(recover), .init_acknowledge(init_ack), .sleep_acknowledge(sleep_ack),
        .irq_wakeup(irq_w), .irq_error(irq_e), .irq_rx(irq_r), .irq_tx(irq_t));

    // Recovery pulses last one cycle and may fall inside a bus transfer
    always @(posedge aclk) begin
        if (recover === 1'b1) rec_count <= rec_count + 1;
        if (fg_ld === 1'b1) fg_count <= fg_count + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                wr_resp = bresp;
                bready <= 1'b0;
            end
        end while (awvalid || wvalid || bready);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                rd_val = rdata;
                rd_resp = rresp;
                rready <= 1'b0;
            end
        end while (arvalid || rready);
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_val, exp);
    endtask : rchk

    task automatic close_out;
        $display("Checks made: %0d, mismatches: %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    initial begin
        repeat (30000) @(posedge aclk);
        err_count++;
        close_out();
    end

    initial begin
        idle(2);
        aresetn <= 1'b1;
        idle(2);
        rchk(OFS_CTRL, 32'h2);
        rchk(OFS_TFLAG, 32'h7);
        rchk(OFS_RFLAG, 32'h0);
        rd(8'h40);
        chk(32'(rd_resp), 32'(RESP_SLVERR));
        wr(8'h40, 32'h1);
        chk(32'(wr_resp), 32'(RESP_SLVERR));
        wr(OFS_CTRL, 32'h3);
        chk(32'(wr_resp), 32'(RESP_OKAY));
        rchk(OFS_STATUS, 32'h1);
        chk(32'(init_ack), 32'h1);
        wr(OFS_CTRL, 32'h1);
        rchk(OFS_STATUS, 32'h0);
        wr(OFS_IEN, 32'h7f);
        idle(2);
        chk(32'(irq_t), 32'h1);
        wr(OFS_TFLAG, 32'h1);
        rchk(OFS_TFLAG, 32'h6);
        chk(32'(tx_sched), 32'h1);
        wr(OFS_TFLAG, 32'h0);
        rchk(OFS_TFLAG, 32'h6);
        chk(32'(irq_t), 32'h1);
        @(posedge aclk) tx_done <= 3'h1;
        @(posedge aclk) tx_done <= 3'h0;
        idle(2);
        rchk(OFS_TFLAG, 32'h7);
        wr(OFS_IEN, 32'h0f);
        idle(2);
        chk(32'(irq_t), 32'h0);
        // Foreground plus five queued frames fill up; the seventh is lost
        repeat (7) begin
            @(posedge aclk) rx_stored <= 1'b1;
            @(posedge aclk) rx_stored <= 1'b0;
            idle(2);
        end
        rchk(OFS_RFLAG, 32'h3);
        chk(32'(irq_e), 32'h1);
        chk(32'(irq_r), 32'h1);
        chk(fg_count, 32'h1);
        wr(OFS_RFLAG, 32'h3);
        idle(2);
        rchk(OFS_RFLAG, 32'h1);
        chk(fg_count, 32'h2);
        chk(32'(irq_e), 32'h0);
        // Frames keep arriving on a full queue while software clears overrun
        rx_stored <= 1'b1;
        wr(OFS_RFLAG, 32'h2);
        rx_stored <= 1'b0;
        rchk(OFS_RFLAG, 32'h3);
        wr(OFS_RFLAG, 32'h2);
        @(posedge aclk) tx_err <= 9'h060;
        rx_err <= 9'h080;
        idle(3);
        rchk(OFS_RFLAG, 32'h65);
        chk(32'(irq_e), 32'h1);
        @(posedge aclk) busoff <= 1'b1;
        cyc = 0;
        while (cyc < 8000 && rec_count == 0) begin
            @(posedge aclk);
            cyc++;
        end
        chk(32'(cyc > 5600 && cyc < 5700), 32'h1);
        busoff <= 1'b0;
        wr(OFS_CTRL, 32'h11);
        @(posedge aclk) busoff <= 1'b1;
        idle(2);
        rchk(OFS_MISC, 32'h1);
        idle(6000);
        chk(32'(rec_count), 32'h1);
        wr(OFS_MISC, 32'h1);
        idle(20);
        chk(32'(rec_count), 32'h2);
        busoff <= 1'b0;
        wr(OFS_CTRL, 32'h0d);
        idle(4);
        rchk(OFS_STATUS, 32'h2);
        chk(32'(sleep_ack), 32'h1);
        @(posedge aclk) dominant <= 1'b1;
        idle(6);
        rd(OFS_RFLAG);
        chk(rd_val & 32'h80, 32'h80);
        chk(32'(irq_w), 32'h1);
        dominant <= 1'b0;
        idle(4);
        wr(OFS_RFLAG, 32'h80);
        idle(2);
        chk(32'(irq_w), 32'h0);
        // Sleep first, then power down: bus activity must still wake
        wr(OFS_CTRL, 32'h0d);
        @(posedge aclk) pdown <= 1'b1;
        idle(2);
        dominant <= 1'b1;
        idle(6);
        chk(32'(irq_w), 32'h1);
        pdown <= 1'b0;
        dominant <= 1'b0;
        close_out();
    end
endmodule : test_cif_flag_ctrl
